// File: eefc_pkg.sv
package eefc_pkg;

  // word byte addresses on the wishbone slave
  localparam logic [3:0] EEFC_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] EEFC_STAT_ADDR   = 4'h4;
  localparam logic [3:0] EEFC_IRQS_ADDR   = 4'h8;
  localparam logic [3:0] EEFC_IRQM_ADDR   = 4'hc;

  // control register layout
  localparam int         EEFC_EDGE_BIT    = 7;
  localparam int         EEFC_CHSEL_LSB   = 0;
  localparam int         EEFC_CHSEL_W     = 4;
  localparam logic [7:0] EEFC_CTRL_WMASK  = 8'h8f;
  localparam logic [7:0] EEFC_CTRL_RST    = 8'h00;
  localparam logic [15:0] EEFC_STAT_RST   = 16'h0000;
  // edges after reset needed to fill both sync flops and the compare flop
  localparam logic [1:0] EEFC_SYNC_FILL   = 2'h3;

  // interrupt status/mask bit positions
  localparam int         EEFC_IRQ_W       = 2;
  localparam int         EEFC_IRQ_CAPT    = 0;
  localparam int         EEFC_IRQ_DONE    = 1;

  localparam int         EEFC_NCH         = 16;
  localparam int         EEFC_CODE_W      = 5;

  typedef struct packed {
    logic       edge_polarity_select;
    logic [3:0] channel_count_select;
  } eefc_ctrl_t;

  typedef struct packed {
    logic                    req;
    logic [EEFC_CODE_W-1:0]  code;
  } eefc_xfer_t;

endpackage : eefc_pkg

// File: eefc_edge_event_flag_capture.sv
`timescale 1ns/10ps
module eefc_edge_event_flag_capture
  import eefc_pkg::*;
#(
  parameter int NCH = EEFC_NCH
) (
  input  wire logic              ref_clk_in,
  input  wire logic              resetn_in,
  input  wire logic [NCH-1:0]    event_inputs_in,
  input  wire logic              low_pins_direction_bit_in,
  input  wire logic              xfer_done_in,
  input  wire logic [3:0]        wb_adr_in,
  input  wire logic [31:0]       wb_dat_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic              wb_we_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  output logic [31:0]            wb_dat_out,
  output logic                   wb_ack_out,
  output logic                   event_pending_irq_out,
  output logic [EEFC_CODE_W-1:0] addr_code_out,
  output logic                   irq_out
);

  // lowest pending index, doubled (input 0 wins)
  function automatic logic [EEFC_CODE_W-1:0] prio_code(input logic [NCH-1:0] f);
    logic [EEFC_CODE_W-1:0] c;
    c = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (f[i]) begin
        c = EEFC_CODE_W'(2 * i);
      end
    end
    return c;
  endfunction : prio_code

  function automatic logic [NCH-1:0] onehot_of(input logic [EEFC_CODE_W-1:0] c);
    logic [NCH-1:0] o;
    o = '0;
    o[c[EEFC_CODE_W-1:1]] = 1'b1;
    return o;
  endfunction : onehot_of

  logic [NCH-1:0]        sync1_r, sync2_r, prev_r;
  logic [NCH-1:0]        sync1_nxt, sync2_nxt, prev_nxt;
  eefc_ctrl_t            ctrl_r, ctrl_nxt;
  logic [NCH-1:0]        stat_r, stat_nxt;
  logic [EEFC_IRQ_W-1:0] irqs_r, irqs_nxt, irqm_r, irqm_nxt;
  logic [31:0]           dat_r, dat_nxt;
  logic                  ack_r, ack_nxt;
  logic                  pend_r, pend_nxt;
  logic [EEFC_CODE_W-1:0] code_r, code_nxt;
  logic                  irq_r, irq_nxt;
  logic [1:0]            warm_r, warm_nxt;

  logic [NCH-1:0]        enable_mask;
  logic [NCH-1:0]        edges;
  logic [NCH-1:0]        clr_mask;
  logic                  bus_req;
  logic                  wr_stb;

  assign bus_req = wb_cyc_in && wb_stb_in && !ack_r;
  assign wr_stb  = bus_req && wb_we_in;

  always_comb begin
    sync1_nxt = event_inputs_in;
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
    warm_nxt  = warm_r;
    if (warm_r != EEFC_SYNC_FILL) begin
      warm_nxt = warm_r + 2'h1;
    end
    for (int i = 0; i < NCH; i++) begin
      enable_mask[i] = (i <= int'(ctrl_r.channel_count_select));
      if (i < 8 && low_pins_direction_bit_in) begin
        enable_mask[i] = 1'b0;
      end
    end
    if (ctrl_r.edge_polarity_select) begin
      edges = prev_r & ~sync2_r;
    end else begin
      edges = ~prev_r & sync2_r;
    end
    edges = edges & enable_mask;
    // a pin already high at reset would look like a rising edge until the chain fills
    if (warm_r != EEFC_SYNC_FILL) begin
      edges = '0;
    end
    // the flag being serviced is the one whose code was presented
    clr_mask = (xfer_done_in && pend_r) ? onehot_of(code_r) : '0;
    // a new edge on the serviced pin wins over its clear
    stat_nxt = (stat_r & ~clr_mask) | edges;
    pend_nxt = |stat_nxt;
    code_nxt = prio_code(stat_nxt);
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    irqm_nxt = irqm_r;
    irqs_nxt = irqs_r;
    ack_nxt  = bus_req;
    dat_nxt  = '0;
    if (wr_stb && wb_sel_in[0]) begin
      if (wb_adr_in == EEFC_CTRL_ADDR) begin
        ctrl_nxt = eefc_ctrl_t'({wb_dat_in[EEFC_EDGE_BIT],
                                 wb_dat_in[EEFC_CHSEL_LSB +: EEFC_CHSEL_W]});
      end else if (wb_adr_in == EEFC_IRQS_ADDR) begin
        irqs_nxt = irqs_r & ~wb_dat_in[EEFC_IRQ_W-1:0];
      end else if (wb_adr_in == EEFC_IRQM_ADDR) begin
        irqm_nxt = wb_dat_in[EEFC_IRQ_W-1:0];
      end
    end
    // sets come after the write-one-to-clear so they win
    if (|edges) begin
      irqs_nxt[EEFC_IRQ_CAPT] = 1'b1;
    end
    if (|clr_mask) begin
      irqs_nxt[EEFC_IRQ_DONE] = 1'b1;
    end
    if (bus_req && !wb_we_in) begin
      if (wb_adr_in == EEFC_CTRL_ADDR) begin
        dat_nxt[7:0] = {ctrl_r.edge_polarity_select, 3'h0,
                        ctrl_r.channel_count_select} & EEFC_CTRL_WMASK;
      end else if (wb_adr_in == EEFC_STAT_ADDR) begin
        // read-only; writes here are dropped
        dat_nxt[15:0] = stat_r;
      end else if (wb_adr_in == EEFC_IRQS_ADDR) begin
        dat_nxt[EEFC_IRQ_W-1:0] = irqs_r;
      end else if (wb_adr_in == EEFC_IRQM_ADDR) begin
        dat_nxt[EEFC_IRQ_W-1:0] = irqm_r;
      end else begin
        dat_nxt = '0;
      end
    end
    irq_nxt = |(irqs_nxt & irqm_nxt);
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
      warm_r  <= 2'h0;
      stat_r  <= EEFC_STAT_RST;
      pend_r  <= 1'b0;
      code_r  <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
      warm_r  <= warm_nxt;
      stat_r  <= stat_nxt;
      pend_r  <= pend_nxt;
      code_r  <= code_nxt;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r  <= eefc_ctrl_t'({EEFC_CTRL_RST[EEFC_EDGE_BIT],
                               EEFC_CTRL_RST[EEFC_CHSEL_LSB +: EEFC_CHSEL_W]});
      irqs_r  <= '0;
      irqm_r  <= '0;
      dat_r   <= '0;
      ack_r   <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      irqs_r  <= irqs_nxt;
      irqm_r  <= irqm_nxt;
      dat_r   <= dat_nxt;
      ack_r   <= ack_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign wb_dat_out            = dat_r;
  assign wb_ack_out            = ack_r;
  assign event_pending_irq_out = pend_r;
  assign addr_code_out         = code_r;
  assign irq_out               = irq_r;

  property p_irq_follows_flags;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      1'b1 |=> (pend_r == (|stat_r));
  endproperty
  a_irq_follows_flags: assert property (p_irq_follows_flags)
    else $error("pending irq disagrees with flags");

  property p_code_lowest;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      stat_r[0] |-> code_r == 5'h00;
  endproperty
  a_code_lowest: assert property (p_code_lowest)
    else $error("input 0 must give code zero");

  property p_code_points_to_flag;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      pend_r |-> stat_r[code_r[4:1]] && code_r[0] == 1'b0;
  endproperty
  a_code_points_to_flag: assert property (p_code_points_to_flag)
    else $error("code does not name a pending flag");

  property p_code_second;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (!stat_r[0] && stat_r[1]) |-> code_r == 5'h02;
  endproperty
  a_code_second: assert property (p_code_second)
    else $error("input 1 must give code two when input 0 is idle");

  property p_code_idle;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      !pend_r |-> code_r == 5'h00;
  endproperty
  a_code_idle: assert property (p_code_idle)
    else $error("code not zero with nothing pending");

  property p_rise_sets;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (!ctrl_r.edge_polarity_select && !prev_r[0] && sync2_r[0] &&
       !low_pins_direction_bit_in && warm_r == EEFC_SYNC_FILL) |=> stat_r[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("rising edge on input 0 not captured");

  property p_fall_sets;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (ctrl_r.edge_polarity_select && prev_r[0] && !sync2_r[0] &&
       !low_pins_direction_bit_in && warm_r == EEFC_SYNC_FILL) |=> stat_r[0];
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("falling edge on input 0 not captured");

  property p_wrong_edge_ignored;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (ctrl_r.edge_polarity_select && !prev_r[1] && sync2_r[1] &&
       !stat_r[1]) |=> !stat_r[1];
  endproperty
  a_wrong_edge_ignored: assert property (p_wrong_edge_ignored)
    else $error("rising edge flagged in falling mode");

  property p_ctrl_write;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (wr_stb && wb_sel_in[0] && wb_adr_in == EEFC_CTRL_ADDR &&
       wb_dat_in[7:0] == 8'hff) |=> ctrl_r == eefc_ctrl_t'(5'h1f);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write did not land on its fields");

  property p_upper_enable;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (ctrl_r.channel_count_select == 4'hf && !ctrl_r.edge_polarity_select &&
       !prev_r[15] && sync2_r[15] && warm_r == EEFC_SYNC_FILL) |=> stat_r[15];
  endproperty
  a_upper_enable: assert property (p_upper_enable)
    else $error("input 15 not captured with all inputs selected");

  property p_disabled_ignored;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (ctrl_r.channel_count_select == 4'h0 && !stat_r[15]) |=> !stat_r[15];
  endproperty
  a_disabled_ignored: assert property (p_disabled_ignored)
    else $error("unselected input set its flag");

  property p_dir_ignored;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (low_pins_direction_bit_in && !stat_r[3]) |=> !stat_r[3];
  endproperty
  a_dir_ignored: assert property (p_dir_ignored)
    else $error("low input flagged while direction bit set");

  property p_dir_spares_high;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (low_pins_direction_bit_in && ctrl_r.channel_count_select == 4'hf &&
       ctrl_r.edge_polarity_select && prev_r[8] && !sync2_r[8] &&
       warm_r == EEFC_SYNC_FILL) |=> stat_r[8];
  endproperty
  a_dir_spares_high: assert property (p_dir_spares_high)
    else $error("direction bit blocked an upper input");

  property p_status_ro;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (wr_stb && wb_adr_in == EEFC_STAT_ADDR && edges == '0 && clr_mask == '0) |=>
        stat_r == $past(stat_r);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status changed by a bus write");

  property p_no_edge_no_flag;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (!stat_r[4] && prev_r[4] == sync2_r[4]) |=> !stat_r[4];
  endproperty
  a_no_edge_no_flag: assert property (p_no_edge_no_flag)
    else $error("flag set without an edge");

  property p_hold_until_done;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (stat_r[15] && !xfer_done_in) |=> stat_r[15];
  endproperty
  a_hold_until_done: assert property (p_hold_until_done)
    else $error("flag dropped without transfer completion");

  property p_done_clears;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (xfer_done_in && pend_r && code_r == 5'h04 && !edges[2]) |=> !stat_r[2];
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("serviced flag not cleared");

  property p_done_spares_others;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (xfer_done_in && pend_r && code_r == 5'h00 && stat_r[1]) |=> stat_r[1];
  endproperty
  a_done_spares_others: assert property (p_done_spares_others)
    else $error("completion cleared a flag that was not serviced");

  property p_ack_pulse;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      ack_r |=> !ack_r;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus acknowledge held longer than one cycle");

  property p_capt_flag;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (|edges) |=> irqs_r[EEFC_IRQ_CAPT];
  endproperty
  a_capt_flag: assert property (p_capt_flag)
    else $error("captured edge did not set its interrupt status");

  property p_ctrl_reserved;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (ack_r && !wb_we_in && wb_adr_in == EEFC_CTRL_ADDR) |-> wb_dat_out[6:4] == 3'h0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("reserved control bits read nonzero");

  property p_status_read;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (bus_req && !wb_we_in && wb_adr_in == EEFC_STAT_ADDR) |=> wb_dat_out[15:0] == $past(stat_r);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read does not show flags");

endmodule : eefc_edge_event_flag_capture

// File: eefc_xfer_engine_model.sv
`timescale 1ns/10ps
module eefc_xfer_engine_model (
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       enable_in,
  input  wire logic       slow_in,
  input  wire logic       pending_in,
  input  wire logic [4:0] code_in,
  output logic            done_out
);
  logic [15:0] count_r [16];
  logic [3:0]  gap_r;
  // the gap lets the flag clear and the code settle before the next service
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_out <= 1'b0;
      gap_r    <= 4'h0;
      for (int i = 0; i < 16; i++) count_r[i] <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      if (gap_r != 4'h0) begin
        gap_r <= gap_r - 4'h1;
      end else if (pending_in && enable_in) begin
        count_r[code_in[4:1]] <= count_r[code_in[4:1]] + 16'h0001;
        done_out              <= 1'b1;
        gap_r                 <= slow_in ? 4'h9 : 4'h3;
      end
    end
  end
endmodule : eefc_xfer_engine_model

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
  import eefc_pkg::*;
  logic        ref_clk_in, resetn_in, dir_bit, done, we, cyc, stb, ack, pend, irq;
  logic        eng_en, slow;
  logic [3:0]  adr, sel;
  logic [4:0]  code;
  logic [15:0] ev;
  logic [31:0] wdat, rdat, q;
  int          miscompares, comparisons;

  eefc_edge_event_flag_capture u_eefc_edge_event_flag_capture (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .event_inputs_in(ev),
    .low_pins_direction_bit_in(dir_bit), .xfer_done_in(done), .wb_adr_in(adr),
    .wb_dat_in(wdat), .wb_sel_in(sel), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_dat_out(rdat), .wb_ack_out(ack), .event_pending_irq_out(pend),
    .addr_code_out(code), .irq_out(irq));

  eefc_xfer_engine_model u_eefc_xfer_engine_model (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .enable_in(eng_en), .slow_in(slow),
    .pending_in(pend), .code_in(code), .done_out(done));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // classic cycle: ack is sampled as it stood just before each rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      miscompares++;
      summarize();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task automatic pins(input logic [15:0] v);
    @(posedge ref_clk_in);
    ev <= v;
    repeat (6) @(posedge ref_clk_in);
  endtask : pins

  task automatic drain(input logic s);
    int n;
    n = 0;
    slow   <= s;
    eng_en <= 1'b1;
    while (pend !== 1'b0 && n < 300) begin
      @(posedge ref_clk_in);
      n++;
    end
    repeat (3) @(posedge ref_clk_in);
    eng_en <= 1'b0;
    if (n >= 300) begin
      miscompares++;
      summarize();
    end
  endtask : drain

  initial begin
    {resetn_in, dir_bit, we, cyc, stb, eng_en, slow} = '0;
    {adr, sel, ev, wdat} = '0;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    rd(EEFC_CTRL_ADDR, 32'h0);
    rd(EEFC_STAT_ADDR, 32'h0);
    wb(1'b1, EEFC_CTRL_ADDR, 32'hff);
    rd(EEFC_CTRL_ADDR, 32'h8f);
    rd(4'h2, 32'h0);
    $display("test registers done");
    wb(1'b1, EEFC_CTRL_ADDR, 32'h0f);
    pins(16'h8001);
    rd(EEFC_STAT_ADDR, 32'h8001);
    chk({31'h0, pend}, 32'h1);
    chk({27'h0, code}, 32'h0);
    wb(1'b1, EEFC_STAT_ADDR, 32'h0);
    rd(EEFC_STAT_ADDR, 32'h8001);
    rd(EEFC_IRQS_ADDR, 32'h1);
    wb(1'b1, EEFC_IRQM_ADDR, 32'h1);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, EEFC_IRQS_ADDR, 32'h1);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h0);
    drain(1'b0);
    rd(EEFC_STAT_ADDR, 32'h0);
    rd(EEFC_IRQS_ADDR, 32'h2);
    $display("test capture and service done");
    pins(16'h0000);
    wb(1'b1, EEFC_CTRL_ADDR, 32'h03);
    pins(16'hffff);
    rd(EEFC_STAT_ADDR, 32'h000f);
    drain(1'b1);
    wb(1'b1, EEFC_CTRL_ADDR, 32'h8f);
    dir_bit <= 1'b1;
    pins(16'h0000);
    rd(EEFC_STAT_ADDR, 32'hff00);
    chk({27'h0, code}, 32'h10);
    drain(1'b0);
    dir_bit <= 1'b0;
    wb(1'b1, EEFC_CTRL_ADDR, 32'h00);
    pins(16'h0003);
    rd(EEFC_STAT_ADDR, 32'h0001);
    drain(1'b0);
    rd(EEFC_STAT_ADDR, 32'h0);
    chk({16'h0, u_eefc_xfer_engine_model.count_r[0]}, 32'h3);
    chk({16'h0, u_eefc_xfer_engine_model.count_r[8]}, 32'h1);
    chk({16'h0, u_eefc_xfer_engine_model.count_r[15]}, 32'h2);
    $display("test channels and edges done");
    summarize();
  end
endmodule : testbench
